/* common/flash_glue_regs.svh */
/*
 * flash_glue_regs.svh: timing counts and command codes for the parallel
 * flash bus controller.
 * Assumes a 10 MHz reference clock (100 ns period) and a flash that takes
 * commands on its low data byte, in 16-bit mode.
 */
// Functional notes
// [R1] flash drives data only while output enable is low during a read
// [R2] output enable stays high for the whole of every write
// [R3] flash latches address and data on the rising write strobe edge
// [R4] write strobe high during reads and returns high between writes
// [R5] chip enable stays low for the full read or write access
// [R6] two chip enables strapped low, primary one from area select
// [R7] chip enable high deselects the flash into standby
// [R8] reset/power-down low resets flash automation and powers it down
// [R9] flash leaves reset in read-array mode with page mode off
// [R10] after every reset exit, set read configuration with page bit 16
// [R11] width-select high gives the 16-bit data path used here
// [R12] the controller bus to the flash is 16 bits wide
// [R13] output enable is the inverse of the read/write direction
// [R14] write strobe falls with the request and rises before its end
// [R15] six-stage chain keeps the write strobe low its minimum time
// [R16] reset/power-down held low at least 35 microseconds
// [R17] wait at least 310 ns after reset release before reading
// [R18] boot image answers at the initial program address A000000h
// [R19] shift register of six stages ends the strobe before request ends
// [R20] read accesses hold enough wait states for access time
`ifndef FLASH_GLUE_REGS_SVH
`define FLASH_GLUE_REGS_SVH

// ************************************************************
// timing
// ************************************************************
`define CLK_PERIOD_NS 100
`define RESET_LOW_MIN_TIME_NS 35000
`define RESET_LOW_CYCLES ((`RESET_LOW_MIN_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RESET_TO_OUTPUT_TIME_NS 310
`define RESET_TO_OUTPUT_CYCLES ((`RESET_TO_OUTPUT_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STROBE_STAGES 6
`define READ_WAIT_CYCLES 2

// ************************************************************
// commands and addresses
// ************************************************************
`define CMD_SET_READ_CONFIG 16'h0060
`define CMD_CONFIRM_READ_CONFIG 16'h0003
`define PAGE_MODE_ENABLE_BIT 16
// processor view; the flash address bus keeps only the low bits
`define BOOT_ADDRESS 28'hA000000

`endif

/* common/flash_glue_pkg.sv */
/*
 * flash_glue_pkg: types for the parallel flash bus controller.
 * Assumes flash_glue_regs.svh supplies the numeric constants.
 */
package flash_glue_pkg;

    typedef enum logic [2:0] {
        ST_RESET = 3'h0,
        ST_RECOVER = 3'h1,
        ST_CFG_CMD = 3'h2,
        ST_CFG_DATA = 3'h3,
        ST_IDLE = 3'h4,
        ST_READ = 3'h5,
        ST_WRITE = 3'h6,
        ST_GAP = 3'h7
    } ctrl_state_t;

endpackage

/* hdl/write_strobe_shaper.sv */
/*
 * write_strobe_shaper: shapes the flash write strobe from a request strobe.
 * Assumes the request strobe is synchronous to ref_clk and stays low
 * longer than the chain.
 */
`timescale 1ns/1ns
`default_nettype none
`include "flash_glue_regs.svh"

module write_strobe_shaper #(
    parameter int STAGES = `STROBE_STAGES
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // strobes
    input wire logic req_write_n,
    output logic flash_write_n,
    output logic done
);

    logic [STAGES-1:0] chain_reg;

    initial begin
        if (STAGES < 2) begin
            $error("write_strobe_shaper: STAGES must be at least 2");
        end
    end

    // [R19] six-stage shift
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            chain_reg <= '0;
        end else if (req_write_n) begin
            chain_reg <= '0;
        end else begin
            chain_reg <= {chain_reg[STAGES-2:0], 1'b1};
        end
    end

    // [R14] low with request, high once chain fills
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            flash_write_n <= 1'b1;
        end else begin
            flash_write_n <= req_write_n | chain_reg[STAGES-1];
        end
    end

    assign done = chain_reg[STAGES-1];

endmodule // write_strobe_shaper

`default_nettype wire

/* hdl/flash_bus_controller.sv */
/*
 * flash_bus_controller: drives a 16-bit asynchronous parallel flash through
 * its pins. Runs reset/power-down, page mode setup, reads and writes.
 * Assumes one request at a time, held until req_done pulses.
 */
`timescale 1ns/1ns
`default_nettype none
`include "flash_glue_regs.svh"

module flash_bus_controller
    import flash_glue_pkg::*;
#(
    parameter int ADDR_W = 26,
    parameter int RESET_CYCLES = `RESET_LOW_CYCLES,
    parameter int RECOVER_CYCLES = `RESET_TO_OUTPUT_CYCLES,
    parameter int READ_WAIT = `READ_WAIT_CYCLES,
    parameter int STAGES = `STROBE_STAGES
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // user requests
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic [15:0] req_wdata,
    input wire logic reset_request,
    output logic req_ready,
    output logic req_done,
    output logic [15:0] req_rdata,
    output logic page_mode_on,
    // flash pins
    output logic [ADDR_W-1:0] flash_addr,
    output logic [15:0] flash_dq_out,
    output logic flash_dq_oe_n,
    input wire logic [15:0] flash_dq_in,
    output logic area_select_n,
    output logic flash_ce1,
    output logic flash_ce2,
    output logic flash_oe_n,
    output logic flash_we_n,
    output logic reset_powerdown_n,
    output logic flash_byte_n
);

    // ************************************************************
    // parameter checks
    // ************************************************************
    initial begin
        if (ADDR_W < 17 || RESET_CYCLES < 1 || RECOVER_CYCLES < 1
            || READ_WAIT < 1 || STAGES < 2) begin
            $error("flash_bus_controller: parameter out of range");
        end
    end

    // ************************************************************
    // state
    // ************************************************************
    ctrl_state_t state_reg;
    ctrl_state_t state_next;
    logic [15:0] count_reg;
    logic req_write_n_reg;
    logic strobe_done;

    function automatic logic is_wr_state(input ctrl_state_t st);
        is_wr_state = (st == ST_WRITE) || (st == ST_CFG_CMD) || (st == ST_CFG_DATA);
    endfunction

    function automatic logic count_hit(input logic [15:0] cnt, input int target);
        count_hit = (cnt >= 16'(target - 1));
    endfunction

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_RESET: begin
                // [R16] hold low 35 us
                if (count_hit(count_reg, RESET_CYCLES)) begin
                    state_next = ST_RECOVER;
                end
            end
            ST_RECOVER: begin
                // [R17] wait 310 ns
                if (count_hit(count_reg, RECOVER_CYCLES)) begin
                    state_next = ST_CFG_CMD;
                end
            end
            ST_CFG_CMD: begin
                if (strobe_done) begin
                    state_next = ST_GAP;
                end
            end
            ST_CFG_DATA: begin
                if (strobe_done) begin
                    state_next = ST_GAP;
                end
            end
            ST_IDLE: begin
                if (reset_request) begin
                    state_next = ST_RESET;
                end else if (req_valid) begin
                    state_next = req_write ? ST_WRITE : ST_READ;
                end
            end
            ST_READ: begin
                // [R20] read wait states
                if (count_hit(count_reg, READ_WAIT)) begin
                    state_next = ST_GAP;
                end
            end
            ST_WRITE: begin
                if (strobe_done) begin
                    state_next = ST_GAP;
                end
            end
            ST_GAP: begin
                if (!page_mode_on && count_reg[0]) begin
                    state_next = ST_CFG_DATA;
                end else begin
                    state_next = ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            state_reg <= ST_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    // cycle counter, also marks second config write in gap
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            count_reg <= '0;
        end else if (state_reg == ST_CFG_CMD && state_next == ST_GAP) begin
            count_reg <= 16'h0001;
        end else if (state_next != state_reg) begin
            count_reg <= '0;
        end else if (count_reg != 16'hFFFF) begin
            count_reg <= count_reg + 16'h0001;
        end
    end

    // [R10] page mode flag set after config data write
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            page_mode_on <= 1'b0;
        end else if (state_reg == ST_RESET) begin
            page_mode_on <= 1'b0;
        end else if (state_reg == ST_CFG_DATA && strobe_done) begin
            page_mode_on <= 1'b1;
        end
    end

    // ************************************************************
    // pins
    // ************************************************************
    // [R8] reset/power-down low in reset state
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            reset_powerdown_n <= 1'b0;
        end else begin
            reset_powerdown_n <= (state_next != ST_RESET);
        end
    end

    // [R13] output enable from inverted direction
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            flash_oe_n <= 1'b1;
        end else begin
            // [R2] output enable high through writes
            flash_oe_n <= (state_next != ST_READ);
        end
    end

    // [R5] chip enable across the access
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            area_select_n <= 1'b1;
        end else begin
            // [R3] select held one cycle past the rising write strobe
            area_select_n <= !(state_next == ST_READ || is_wr_state(state_next)
                || is_wr_state(state_reg));
        end
    end

    // [R6] secondary enables strapped low; [R11] 16-bit mode
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            flash_ce1 <= 1'b0;
            flash_ce2 <= 1'b0;
            flash_byte_n <= 1'b1;
        end else begin
            flash_ce1 <= 1'b0;
            flash_ce2 <= 1'b0;
            flash_byte_n <= 1'b1;
        end
    end

    // [R12] 16-bit data, ADDR_W-bit address
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            flash_addr <= '0;
            flash_dq_out <= '0;
            flash_dq_oe_n <= 1'b1;
        end else begin
            // data driven until after the strobe has risen
            flash_dq_oe_n <= !(is_wr_state(state_next) || is_wr_state(state_reg));
            if (state_reg == ST_RECOVER && state_next == ST_CFG_CMD) begin
                // [R18] config address is the boot base with page mode bit 16 set
                flash_addr <= ADDR_W'(`BOOT_ADDRESS)
                    | (ADDR_W'(1) << `PAGE_MODE_ENABLE_BIT);
                flash_dq_out <= `CMD_SET_READ_CONFIG;
            end else if (state_reg == ST_GAP && state_next == ST_CFG_DATA) begin
                flash_dq_out <= `CMD_CONFIRM_READ_CONFIG;
            end else if (state_reg == ST_IDLE && state_next != ST_IDLE
                && state_next != ST_RESET) begin
                flash_addr <= req_addr;
                flash_dq_out <= req_wdata;
            end
        end
    end

    // [R4] request strobe low only in write phases, high in gap
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            req_write_n_reg <= 1'b1;
        end else begin
            req_write_n_reg <= !is_wr_state(state_next) || strobe_done;
        end
    end

    // [R15] six-stage strobe timing
    write_strobe_shaper #(
        .STAGES(STAGES)
    ) u_shaper (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .req_write_n(req_write_n_reg),
        .flash_write_n(flash_we_n),
        .done(strobe_done)
    );

    // ************************************************************
    // user side
    // ************************************************************
    // [R1] capture data while output enable is low
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            req_rdata <= '0;
        end else if (state_reg == ST_READ && count_hit(count_reg, READ_WAIT)) begin
            req_rdata <= flash_dq_in;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            req_done <= 1'b0;
            req_ready <= 1'b0;
        end else begin
            req_done <= (state_reg == ST_READ && count_hit(count_reg, READ_WAIT))
                || (state_reg == ST_WRITE && strobe_done);
            req_ready <= (state_next == ST_IDLE);
        end
    end

endmodule // flash_bus_controller

`default_nettype wire

/* testbench/flash_glue_asserts.sv */
/* flash_glue_asserts: pin timing checks for flash_bus_controller.
   Assumes one ref_clk domain and a bind onto the controller's ports. */
`timescale 1ns/1ns
`default_nettype none
module flash_glue_asserts #(
    parameter int RESET_CYCLES = 350
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // user side
    input wire logic req_ready,
    input wire logic req_done,
    input wire logic page_mode_on,
    // flash pins
    input wire logic area_select_n,
    input wire logic flash_ce1,
    input wire logic flash_ce2,
    input wire logic flash_oe_n,
    input wire logic flash_we_n,
    input wire logic reset_powerdown_n,
    input wire logic flash_byte_n
);
    // ********
    // cycles spent in flash reset
    // ********
    logic [15:0] low_cnt_reg;
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            low_cnt_reg <= 16'h0000;
        end else if (!reset_powerdown_n) begin
            low_cnt_reg <= low_cnt_reg + 16'h0001;
        end else begin
            low_cnt_reg <= 16'h0000;
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    a_oe_write_off: assert property (!flash_we_n |-> flash_oe_n)
        else $error("output enable low during write");
    a_we_read_off: assert property (!flash_oe_n |-> flash_we_n)
        else $error("write strobe low during read");
    a_ce_held: assert property ((!flash_we_n || !flash_oe_n) |-> !area_select_n)
        else $error("chip enable high during access");
    a_straps_low: assert property (flash_ce1 == 1'b0 && flash_ce2 == 1'b0)
        else $error("secondary chip enables not low");
    a_width_wide: assert property (flash_byte_n)
        else $error("width select not 16-bit");
    a_we_low_len: assert property ($fell(flash_we_n) |-> (!flash_we_n)[*5] ##[1:3] flash_we_n)
        else $error("write strobe low time wrong");
    a_we_ends_first: assert property ($rose(flash_we_n) && page_mode_on && $past(page_mode_on)
        |-> ##[0:3] req_done)
        else $error("write strobe not released before access end");
    a_reset_len: assert property ($rose(reset_powerdown_n) |-> low_cnt_reg >= RESET_CYCLES - 1)
        else $error("flash reset pulse too short");
    a_recover_wait: assert property ($rose(reset_powerdown_n) |-> flash_oe_n[*4])
        else $error("read too soon after flash reset");
    a_ready_page: assert property (req_ready |-> page_mode_on)
        else $error("ready before page mode set");
    a_read_wait: assert property ($fell(flash_oe_n) |-> (!flash_oe_n)[*2] ##[0:3] req_done)
        else $error("read access too short or unanswered");
endmodule // flash_glue_asserts
bind flash_bus_controller flash_glue_asserts #(.RESET_CYCLES(RESET_CYCLES)) u_chk (
    .ref_clk(ref_clk), .rstn(rstn), .req_ready(req_ready), .req_done(req_done),
    .page_mode_on(page_mode_on), .area_select_n(area_select_n), .flash_ce1(flash_ce1),
    .flash_ce2(flash_ce2), .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n),
    .reset_powerdown_n(reset_powerdown_n), .flash_byte_n(flash_byte_n));
`default_nettype wire

/* testbench/flash_model.sv */
/* flash_model: behavioural 16-bit parallel flash with read configuration.
   Assumes the controller's split data bus; resolves the shared bus here. */
`timescale 1ns/1ns
`default_nettype none
`include "flash_glue_regs.svh"
module flash_model (
    // clock for the released-bus pattern
    input wire logic ref_clk,
    // flash pins
    input wire logic [25:0] flash_addr,
    input wire logic [15:0] flash_dq_out,
    input wire logic flash_dq_oe_n,
    output logic [15:0] flash_dq_in,
    input wire logic area_select_n,
    input wire logic flash_ce1,
    input wire logic flash_ce2,
    input wire logic flash_oe_n,
    input wire logic flash_we_n,
    input wire logic reset_powerdown_n,
    input wire logic flash_byte_n,
    // status
    output logic page_en,
    output logic [7:0] wr_count
);
    logic [15:0] mem [0:15];
    logic [15:0] last;
    logic pend;
    logic sel;
    initial begin
        for (int i = 0; i < 16; i++) mem[i] = 16'h0000;
        page_en = 1'b0;
        pend = 1'b0;
        wr_count = 8'h00;
        last = 16'h0000;
    end
    assign sel = !area_select_n && !flash_ce1 && !flash_ce2 && reset_powerdown_n;
    assign flash_dq_in = !flash_dq_oe_n ? flash_dq_out :
        (sel && flash_byte_n && !flash_oe_n) ? mem[flash_addr[3:0]] : ~last;
    always @(posedge ref_clk) last <= flash_dq_in;
    always @(posedge flash_we_n) begin
        if (sel) begin
            wr_count <= wr_count + 8'h01;
            pend <= (flash_dq_in == `CMD_SET_READ_CONFIG);
            if (pend && flash_dq_in == `CMD_CONFIRM_READ_CONFIG) begin
                page_en <= flash_addr[`PAGE_MODE_ENABLE_BIT];
            end else if (flash_dq_in != `CMD_SET_READ_CONFIG) begin
                mem[flash_addr[3:0]] <= flash_dq_in;
            end
        end
    end
    always @(negedge reset_powerdown_n) begin
        page_en <= 1'b0;
        pend <= 1'b0;
    end
endmodule // flash_model
`default_nettype wire

/* testbench/flash_bus_controller_tb.sv */
/* flash_bus_controller_tb: scenario bench for the flash bus controller.
   Assumes flash_model as the far side and short reset counts. */
`timescale 1ns/1ns
`default_nettype none
module flash_bus_controller_tb;
    logic ref_clk, rstn, req_valid, req_write, reset_request, req_ready, req_done;
    logic page_mode_on, dq_oe_n, cs_n, ce1, ce2, oe_n, we_n, flash_pd_n, byte_n, page_en;
    logic [25:0] req_addr, f_addr;
    logic [15:0] req_wdata, req_rdata, dq_out, dq_in;
    logic [7:0] wr_count;
    int err_count, n_compared;
    flash_bus_controller #(.RESET_CYCLES(4), .RECOVER_CYCLES(4)) u_dut (
        .ref_clk(ref_clk), .rstn(rstn), .req_valid(req_valid), .req_write(req_write),
        .req_addr(req_addr), .req_wdata(req_wdata), .reset_request(reset_request),
        .req_ready(req_ready), .req_done(req_done), .req_rdata(req_rdata),
        .page_mode_on(page_mode_on), .flash_addr(f_addr), .flash_dq_out(dq_out),
        .flash_dq_oe_n(dq_oe_n), .flash_dq_in(dq_in), .area_select_n(cs_n),
        .flash_ce1(ce1), .flash_ce2(ce2), .flash_oe_n(oe_n), .flash_we_n(we_n),
        .reset_powerdown_n(flash_pd_n), .flash_byte_n(byte_n));
    flash_model u_flash (
        .ref_clk(ref_clk), .flash_addr(f_addr), .flash_dq_out(dq_out),
        .flash_dq_oe_n(dq_oe_n), .flash_dq_in(dq_in), .area_select_n(cs_n),
        .flash_ce1(ce1), .flash_ce2(ce2), .flash_oe_n(oe_n), .flash_we_n(we_n),
        .reset_powerdown_n(flash_pd_n), .flash_byte_n(byte_n), .page_en(page_en),
        .wr_count(wr_count));
    // ********
    // helpers
    // ********
    task automatic give_verdict();
        if (err_count == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic check16(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wait_on(input logic sig_is_ready, input int lim);
        int i;
        for (i = 0; i < lim; i++) begin
            @(negedge ref_clk);
            if ((sig_is_ready ? req_ready : !flash_pd_n) === 1'b1) return;
        end
        err_count++;
        $display("ERROR %0t: wait timed out", $time);
        give_verdict();
    endtask
    task automatic access(input logic wr, input logic [25:0] a, input logic [15:0] d,
                          output logic [15:0] q);
        int i;
        wait_on(1'b1, 400);
        @(posedge ref_clk);
        req_valid <= 1'b1;
        req_write <= wr;
        req_addr <= a;
        req_wdata <= d;
        for (i = 0; i < 40 && req_done !== 1'b1; i++) @(negedge ref_clk);
        if (i == 40) begin
            err_count++;
            $display("ERROR %0t: access not answered", $time);
            give_verdict();
        end
        q = req_rdata;
        @(posedge ref_clk);
        req_valid <= 1'b0;
    endtask
    // ********
    // scenarios
    // ********
    task automatic t_write_read();
        logic [15:0] q;
        logic [7:0] w0;
        w0 = wr_count;
        access(1'b1, 26'h2000001, 16'hA5C3, q);
        access(1'b1, 26'h2000002, 16'h5A3C, q);
        check16({8'h00, wr_count - w0}, 16'h0002);
        access(1'b0, 26'h2000001, 16'h0000, q);
        check16(q, 16'hA5C3);
        access(1'b0, 26'h2000002, 16'h0000, q);
        check16(q, 16'h5A3C);
    endtask
    task automatic t_flash_reset(input logic hard);
        logic [15:0] q;
        wait_on(1'b1, 400);
        @(posedge ref_clk);
        if (hard) rstn <= 1'b0;
        else reset_request <= 1'b1;
        wait_on(1'b0, 40);
        @(negedge ref_clk);
        check16({14'h0000, page_mode_on, page_en}, 16'h0000);
        check16({14'h0000, cs_n, flash_pd_n}, 16'h0002);
        @(posedge ref_clk);
        rstn <= 1'b1;
        reset_request <= 1'b0;
        wait_on(1'b1, 400);
        check16({14'h0000, page_mode_on, page_en}, 16'h0003);
        access(1'b0, 26'h2000002, 16'h0000, q);
        check16(q, 16'h5A3C);
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    initial begin
        rstn = 1'b0;
        req_valid = 1'b0;
        req_write = 1'b0;
        reset_request = 1'b0;
        req_addr = 26'h0000000;
        req_wdata = 16'h0000;
        err_count = 0;
        n_compared = 0;
        repeat (12) @(posedge ref_clk);
        rstn <= 1'b1;
        wait_on(1'b1, 400);
        check16({14'h0000, page_mode_on, page_en}, 16'h0003);
        t_write_read();
        t_flash_reset(1'b0);
        t_flash_reset(1'b1);
        give_verdict();
    end
endmodule // flash_bus_controller_tb
`default_nettype wire
